// ==== shared/acr_map.vh ====
`ifndef ACR_MAP_VH
`define ACR_MAP_VH
// Register indices; byte address is four times the index
`define ACR_IDX_TRIM 4'h3
`define ACR_IDX_CLAMP 4'h4
`define ACR_IDX_SER 4'h5
`define ACR_ADDR_W 6
// Baseline values
`define ACR_TRIM_BASE 8'h5b
`define ACR_CLAMP_BASE 8'h74
`define ACR_SER_BASE 8'h0e
// Trim fields
`define ACR_TRIM_RSV_HI 7
`define ACR_TRIM_RSV_LO 6
`define ACR_TRIM2_HI 5
`define ACR_TRIM2_LO 3
`define ACR_TRIM1_HI 2
`define ACR_TRIM1_LO 0
// Clamp fields
`define ACR_CLAMP_BUF_BIT 6
`define ACR_CLAMP_OE_BIT 5
`define ACR_CLAMP_LVL_HI 4
`define ACR_CLAMP_LVL_LO 0
`define ACR_CLAMP_LVL_MAX 5'h1d
// Serial output fields
`define ACR_SER_RST_BIT 7
`define ACR_SER_QUAD_BIT 3
`define ACR_SER_DRV_BIT 2
`define ACR_SER_SWING_HI 1
`define ACR_SER_SWING_LO 0
// Writable bit masks; bits outside a mask read zero (trim reserved bits 7:6 are writable and read back)
`define ACR_TRIM_MASK 8'hff
`define ACR_CLAMP_MASK 8'h7f
`define ACR_SER_MASK 8'h8f
`endif

// ==== hdl/acr_regs.v ====
// How it works
// - Trim field two: 000/001/011/111 power steps
// - Trim field one uses same encoding
// - Bit 6 buffers ladder onto clamp pin
// - Bit 5 makes clamp pin an output
// - Clamp level 200mV plus 100mV per code
// - Serializer reset bit held until host clears
// - Bit 3 selects dual or quad lanes
// - Bit 2 enables all four output drivers in quad mode, only lanes one and two in dual
// - Dual lane keeps lanes zero, three off
// - Swing field selects amplitude and common mode
//
// Added by the designer: register access over Wishbone.
`include "acr_map.vh"

module acr_regs (
	input wire clk_i,
	input wire rst_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [`ACR_ADDR_W-1:0] wb_adr_i,
	input wire [31:0] wb_dat_i,
	input wire [3:0] wb_sel_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	output reg [1:0] adc_trim2_level_o,
	output reg [1:0] adc_trim1_level_o,
	output reg clamp_buffer_en_o,
	output reg clamp_voltage_pin_oe_o,
	output reg [4:0] clamp_level_o,
	output reg serializer_reset_o,
	output reg quad_lane_o,
	output reg [3:0] lane_enable_o,
	output reg [1:0] swing_sel_o,
	output reg common_mode_low_o
);

	reg [7:0] trim_q;
	reg [7:0] clamp_q;
	reg [7:0] ser_q;
	reg [31:0] rdata_d;
	reg [1:0] lvl2_d;
	reg [1:0] lvl1_d;
	reg [3:0] lanes_d;
	wire req;
	wire wr;
	wire [3:0] idx;
	wire hit;

	assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr = req & wb_we_i & wb_sel_i[0];
	assign idx = wb_adr_i[`ACR_ADDR_W-1:2];
	assign hit = (wb_adr_i[1:0] == 2'b00) &&
		(idx == `ACR_IDX_TRIM || idx == `ACR_IDX_CLAMP || idx == `ACR_IDX_SER);

	// Decode of non-binary trim code to power step 0..3 (25/50/75/100 %)
	function [1:0] trim_step;
		input [2:0] code;
		begin
			case (code)
				3'h0: trim_step = 2'h0;
				3'h1: trim_step = 2'h1;
				3'h3: trim_step = 2'h2;
				3'h7: trim_step = 2'h3;
				default: trim_step = 2'h2;
			endcase
		end
	endfunction

	// Registers come up at baseline; the host still rewrites them.
	// baseline load
	always @(posedge clk_i) begin
		if (rst_i) begin
			trim_q <= `ACR_TRIM_BASE;
			clamp_q <= `ACR_CLAMP_BASE;
			ser_q <= `ACR_SER_BASE;
		end else if (wr && hit) begin
			case (idx)
				`ACR_IDX_TRIM: trim_q <= wb_dat_i[7:0] & `ACR_TRIM_MASK;
				`ACR_IDX_CLAMP: clamp_q <= wb_dat_i[7:0] & `ACR_CLAMP_MASK;
				`ACR_IDX_SER: ser_q <= wb_dat_i[7:0] & `ACR_SER_MASK;
				default: ser_q <= ser_q;
			endcase
		end
	end

	always @* begin
		rdata_d = 32'h0000_0000;
		if (hit) begin
			case (idx)
				`ACR_IDX_TRIM: rdata_d[7:0] = trim_q;
				`ACR_IDX_CLAMP: rdata_d[7:0] = clamp_q;
				`ACR_IDX_SER: rdata_d[7:0] = ser_q;
				default: rdata_d = 32'h0000_0000;
			endcase
		end
	end

	// Unmapped addresses ack with zero data; writes there are dropped
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= req;
			wb_dat_o <= req ? rdata_d : 32'h0000_0000;
		end
	end

	always @* begin
		lvl2_d = trim_step(trim_q[`ACR_TRIM2_HI:`ACR_TRIM2_LO]);
		lvl1_d = trim_step(trim_q[`ACR_TRIM1_HI:`ACR_TRIM1_LO]);
		lanes_d = ser_q[`ACR_SER_DRV_BIT] ? 4'hf : 4'h0;
		if (!ser_q[`ACR_SER_QUAD_BIT])
			lanes_d = lanes_d & 4'h6;
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			adc_trim2_level_o <= 2'h2;
			adc_trim1_level_o <= 2'h2;
			clamp_buffer_en_o <= 1'b1;
			clamp_voltage_pin_oe_o <= 1'b1;
			clamp_level_o <= 5'h14;
			serializer_reset_o <= 1'b0;
			quad_lane_o <= 1'b1;
			lane_enable_o <= 4'hf;
			swing_sel_o <= 2'h2;
			common_mode_low_o <= 1'b1;
		end else begin
			adc_trim2_level_o <= lvl2_d;
			adc_trim1_level_o <= lvl1_d;
			clamp_buffer_en_o <= clamp_q[`ACR_CLAMP_BUF_BIT];
			clamp_voltage_pin_oe_o <= clamp_q[`ACR_CLAMP_OE_BIT];
			// level code; codes above max saturate
			if (clamp_q[`ACR_CLAMP_LVL_HI:`ACR_CLAMP_LVL_LO] > `ACR_CLAMP_LVL_MAX)
				clamp_level_o <= `ACR_CLAMP_LVL_MAX;
			else
				clamp_level_o <= clamp_q[`ACR_CLAMP_LVL_HI:`ACR_CLAMP_LVL_LO];
			serializer_reset_o <= ser_q[`ACR_SER_RST_BIT];
			quad_lane_o <= ser_q[`ACR_SER_QUAD_BIT];
			lane_enable_o <= lanes_d;
			swing_sel_o <= ser_q[`ACR_SER_SWING_HI:`ACR_SER_SWING_LO];
			common_mode_low_o <= ser_q[`ACR_SER_SWING_HI];
		end
	end

endmodule // acr_regs

// ==== testbench/acr_regs_props.sv ====
module acr_chk(
	input wire clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
	input wire [5:0] wb_adr_i,
	input wire [31:0] wb_dat_i,
	input wire [3:0] wb_sel_i, lane_enable_o,
	input wire [1:0] adc_trim2_level_o, adc_trim1_level_o, swing_sel_o,
	input wire clamp_buffer_en_o, clamp_voltage_pin_oe_o,
	input wire serializer_reset_o, quad_lane_o, common_mode_low_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Write taken at this edge
	wire wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && !wb_ack_o && wb_adr_i[1:0] == 2'h0;
	wire [3:0] ix = wb_adr_i[5:2];
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_dual; !quad_lane_o |-> !lane_enable_o[0] && !lane_enable_o[3]; endproperty
	a_dual: assert property (p_dual) else $error("outer lanes on");
	property p_cm; common_mode_low_o == swing_sel_o[1]; endproperty
	a_cm: assert property (p_cm) else $error("common mode");
	property p_srst; wr && ix == 4'h5 |-> ##2 serializer_reset_o == $past(wb_dat_i[7], 2); endproperty
	a_srst: assert property (p_srst) else $error("serializer reset");
	property p_quad; wr && ix == 4'h5 |-> ##2 quad_lane_o == $past(wb_dat_i[3], 2); endproperty
	a_quad: assert property (p_quad) else $error("lane mode");
	property p_buf; wr && ix == 4'h4 |-> ##2 clamp_buffer_en_o == $past(wb_dat_i[6], 2); endproperty
	a_buf: assert property (p_buf) else $error("clamp buffer");
	property p_oe; wr && ix == 4'h4 |-> ##2 clamp_voltage_pin_oe_o == $past(wb_dat_i[5], 2); endproperty
	a_oe: assert property (p_oe) else $error("clamp pin enable");
	property p_t2; wr && ix == 4'h3 && wb_dat_i[5:3] == 3'h7 |-> ##2 adc_trim2_level_o == 2'h3; endproperty
	a_t2: assert property (p_t2) else $error("trim two");
	property p_t1; wr && ix == 4'h3 && wb_dat_i[2:0] == 3'h0 |-> ##2 adc_trim1_level_o == 2'h0; endproperty
	a_t1: assert property (p_t1) else $error("trim one");
endmodule // acr_chk
bind acr_regs acr_chk u_chk(.*);

// ==== testbench/tb.sv ====
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
	logic [5:0] wb_adr_i = 6'h00;
	logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, r;
	logic [3:0] wb_sel_i = 4'h0, lane_enable_o;
	logic wb_ack_o, clamp_buffer_en_o, clamp_voltage_pin_oe_o, serializer_reset_o;
	logic quad_lane_o, common_mode_low_o;
	logic [1:0] adc_trim2_level_o, adc_trim1_level_o, swing_sel_o;
	logic [4:0] clamp_level_o;
	int n_fail = 0, cmp_count = 0, cyc_n = 0;
	wire [8:0] ser_v = {serializer_reset_o, quad_lane_o, lane_enable_o, swing_sel_o, common_mode_low_o};
	wire [6:0] clp_v = {clamp_buffer_en_o, clamp_voltage_pin_oe_o, clamp_level_o};
	acr_regs u_dut(.*);
	always #4 clk_i = ~clk_i;
	task print_verdict;
		$display("mismatches %0d compares %0d", n_fail, cmp_count);
		if (n_fail == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge clk_i) if (++cyc_n == 500) begin
		n_fail++;
		print_verdict();
	end
	task chk(input logic [31:0] s, e);
		cmp_count++;
		if (s !== e) begin
			n_fail++;
			$display("BAD %0t %h %h", $time, s, e);
		end
	endtask
	// One classic cycle, then one idle cycle
	task bus(input logic w, input logic [5:0] a, input logic [7:0] d);
		wb_cyc_i <= 1; wb_stb_i <= 1; wb_we_i <= w; wb_adr_i <= a;
		wb_dat_i <= {24'h00_0000, d}; wb_sel_i <= 4'h1;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		r = wb_dat_o;
		wb_cyc_i <= 0; wb_stb_i <= 0;
		@(posedge clk_i);
	endtask
	task t_reset;
		bus(0, 6'h0c, 8'h00); chk(r, 32'h0000_005b);
		bus(0, 6'h10, 8'h00); chk(r, 32'h0000_0074);
		bus(0, 6'h14, 8'h00); chk(r, 32'h0000_000e);
		bus(0, 6'h18, 8'h00); chk(r, 32'h0000_0000);
	endtask
	task t_trim;
		logic [2:0] c[4] = '{3'h0, 3'h1, 3'h3, 3'h7};
		for (int i = 0; i < 4; i++) begin
			bus(1, 6'h0c, {2'h1, c[i], c[3-i]});
			chk({adc_trim2_level_o, adc_trim1_level_o}, {i[1:0], 2'(3-i)});
		end
	endtask
	task t_clamp;
		bus(1, 6'h10, 8'h9d); bus(0, 6'h10, 8'h00); chk(r, 32'h0000_001d);
		chk(clp_v, 7'h1d);
		// stimulus keeps clamp codes at or below 1d
		bus(1, 6'h10, 8'h60); chk(clp_v, 7'h60);
	endtask
	task t_ser;
		bus(1, 6'h14, 8'hf3); bus(0, 6'h14, 8'h00); chk(r, 32'h0000_0083);
		chk(ser_v, 9'h107);
		bus(1, 6'h14, 8'h84); chk(ser_v, 9'h130);
		bus(1, 6'h14, 8'h0d); chk(ser_v, 9'h0fa);
	endtask
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 0;
		t_reset; t_trim; t_clamp; t_ser;
		print_verdict();
	end
endmodule // tb
